// ### rgbw_pkg.sv
package rgbw_pkg;

  // ==========================================================
  // Protocol bytes
  localparam logic [7:0] PREAMBLE_BYTE = 8'h55;
  localparam logic [7:0] MODE_WHEEL    = 8'hA4;
  localparam logic [7:0] MODE_BYPASS   = 8'h21;
  localparam logic [3:0] CMD_BYTES     = 4'h8;
  localparam logic [3:0] BYTE_BITS     = 4'h8;

  // ==========================================================
  // Reset hold and datapath constants
  localparam int         RST_HOLD_CYCLES = 128;
  localparam logic [7:0] HUE_STEP        = 8'h06;
  localparam logic [7:0] COMP_MAX        = 8'hFF;
  localparam logic [7:0] COMP_MIN        = 8'h00;
  localparam logic [2:0] MUL_LAST_SLOT   = 3'h7;
  localparam logic [7:0] DUTY_RESET      = 8'h00;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic [7:0] intensity;
    logic [7:0] colorIndex;
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
    logic [7:0] white;
    logic       bypass;
  } cmd_t;

  typedef struct packed {
    logic [7:0] r;
    logic [7:0] g;
    logic [7:0] b;
    logic [7:0] w;
  } rgbw_t;

endpackage

// ### spi_byte_rx.sv
`timescale 1ns/1ps
`default_nettype none
module spi_byte_rx (
  // Clock, reset, enable
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       en,
  // Serial pins, synchronous to sys_clk
  input  wire logic       csN,
  input  wire logic       sck,
  input  wire logic       mosi,
  // Received byte
  output logic [7:0]      rxByte,
  output logic            rxValid
);
  import rgbw_pkg::*;

  logic       sckPrev_q;
  logic       csPrev_q;
  logic [7:0] shift_q;
  logic [3:0] bitCnt_q;

  // ==========================================================
  // Shifting, one byte per select window
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sckPrev_q <= 1'b0;
      csPrev_q  <= 1'b1;
      shift_q   <= 8'h00;
      bitCnt_q  <= 4'h0;
    end else if (en) begin
      sckPrev_q <= sck;
      csPrev_q  <= csN;
      if (csN) begin
        bitCnt_q <= 4'h0;
      end else if (sck && !sckPrev_q && bitCnt_q != BYTE_BITS) begin
        shift_q  <= {shift_q[6:0], mosi};
        bitCnt_q <= bitCnt_q + 4'h1;
      end
    end
  end

  // Byte only counts when select rises after at least eight bits; clocks past the eighth are ignored
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rxValid <= 1'b0;
      rxByte  <= 8'h00;
    end else if (en) begin
      rxValid <= csN && !csPrev_q && (bitCnt_q == BYTE_BITS);
      rxByte  <= shift_q;
    end
  end

endmodule
`default_nettype wire

// ### pwm_channel.sv
`timescale 1ns/1ps
`default_nettype none
module pwm_channel #(
  parameter int WIDTH = 8
) (
  // Clock, reset, enable
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic             en,
  // Shared period counter and requested duty
  input  wire logic [WIDTH-1:0] cnt,
  input  wire logic [WIDTH-1:0] duty,
  // Modulated output
  output logic                  pwm
);

  logic [WIDTH-1:0] dutyLive_q;
  logic [WIDTH-1:0] dutyEff;

  // New duty used from the first count of a period only
  assign dutyEff = (cnt == '0) ? duty : dutyLive_q;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      dutyLive_q <= '0;
      pwm        <= 1'b0;
    end else if (en) begin
      if (cnt == '0) begin
        dutyLive_q <= duty;
      end
      pwm <= (cnt < dutyEff);
    end
  end

endmodule
`default_nettype wire

// ### rgbw_color_pwm.sv
// Operation
// - SPI slave Mode 0, eight-byte commands
// - Byte order fixed; start only on preamble
// - Mode A4 wheel, 21 bypass; full-range bytes
// - Chip select toggles around every byte
// - Garbage bytes return receiver to idle
// - Bypass sends raw RGBW to PWM
// - Wheel mode ignores received RGB
// - Hue counter steps until index reached
// - Tint adds white with saturation
// - One shared multiplier, two fast cycles
// - Keep upper byte of each product
// - Bypass reaches PWM in one cycle
// - PWM period 256 prescaled cycles
// - Duty changes only at period start
// - System runs at half clock rate
// - Active-low reset, clock keeps running
// - Hold logic in reset 128 cycles
// - Debug enable drives internal signals out
// - Four PWM outputs, one per colour
`timescale 1ns/1ps
`default_nettype none
module rgbw_color_pwm #(
  parameter int PWM_BITS = 8
) (
  // Clock, reset, enable
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  input  wire logic        ce,
  // SPI slave pins
  input  wire logic        csN,
  input  wire logic        sck,
  input  wire logic        mosi,
  // Debug pins
  input  wire logic        debugEn,
  output logic [7:0]       debugOut,
  output logic [7:0]       debugOe,
  // PWM outputs, red green blue white
  output logic [3:0]       dedicatedOutputs,
  // Status
  output logic             busy,
  output rgbw_pkg::cmd_t   activeCmd
);
  import rgbw_pkg::*;

  // ==========================================================
  // Reset manager
  logic [7:0] holdCnt_q;
  logic       holdDone_q;
  logic       sysRst;

  // Asynchronous entry, counted release; logic sees a synchronous reset
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      holdCnt_q  <= 8'h00;
      holdDone_q <= 1'b0;
    end else if (ce && !holdDone_q) begin
      if (holdCnt_q == 8'(RST_HOLD_CYCLES - 1)) begin
        holdDone_q <= 1'b1;
      end
      holdCnt_q <= holdCnt_q + 8'h01;
    end
  end
  assign sysRst = !holdDone_q;

  // ==========================================================
  // Clock manager: system tick at half rate
  logic sysTick_q;
  logic sysEn;

  // An enable rather than a divided clock keeps one clock tree
  always_ff @(posedge sys_clk) begin
    if (sysRst) begin
      sysTick_q <= 1'b0;
    end else if (ce) begin
      sysTick_q <= !sysTick_q;
    end
  end
  assign sysEn = ce && sysTick_q;

  // ==========================================================
  // Byte receiver
  logic [7:0] rxByte;
  logic       rxValid;
  logic       rxStrobe;

  spi_byte_rx u_rx (
    .sys_clk (sys_clk),
    .rst     (sysRst),
    .en      (sysEn),
    .csN     (csN),
    .sck     (sck),
    .mosi    (mosi),
    .rxByte  (rxByte),
    .rxValid (rxValid)
  );
  assign rxStrobe = sysEn && rxValid;

  // ==========================================================
  // Packet assembler
  logic [3:0] byteIdx_q;
  cmd_t       stage_q;
  logic       cmdNew_q;
  logic       cmdTaken;
  logic       lastByte;
  logic       modeOk;

  assign lastByte = rxStrobe && (byteIdx_q == CMD_BYTES - 4'h1);
  assign modeOk   = (rxByte == MODE_WHEEL) || (rxByte == MODE_BYPASS);

  // Index 0 means hunting for the preamble; a bad packet runs out in
  // at most seven more bytes, so eight garbage bytes always resync
  always_ff @(posedge sys_clk) begin
    if (sysRst) begin
      byteIdx_q <= 4'h0;
      stage_q   <= '0;
    end else if (rxStrobe) begin
      case (byteIdx_q)
        4'h0: begin
          if (rxByte == PREAMBLE_BYTE) begin
            byteIdx_q <= 4'h1;
          end
        end
        4'h1: stage_q.intensity  <= rxByte;
        4'h2: stage_q.colorIndex <= rxByte;
        4'h3: stage_q.red        <= rxByte;
        4'h4: stage_q.green      <= rxByte;
        4'h5: stage_q.blue       <= rxByte;
        4'h6: stage_q.white      <= rxByte;
        default: stage_q.bypass  <= (rxByte == MODE_BYPASS);
      endcase
      if (byteIdx_q != 4'h0) begin
        byteIdx_q <= lastByte ? 4'h0 : byteIdx_q + 4'h1;
      end
    end
  end

  // Completed command register; a new packet beats the consume
  always_ff @(posedge sys_clk) begin
    if (sysRst) begin
      activeCmd <= '0;
      cmdNew_q  <= 1'b0;
    end else if (lastByte && modeOk) begin
      activeCmd        <= stage_q;
      activeCmd.bypass <= (rxByte == MODE_BYPASS);
      cmdNew_q         <= 1'b1;
    end else if (cmdTaken) begin
      cmdNew_q <= 1'b0;
    end
  end

  // ==========================================================
  // Colour wheel unit state machine
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_HUE  = 5'b00010,
    ST_TINT = 5'b00100,
    ST_MUL  = 5'b01000,
    ST_OUT  = 5'b10000
  } cw_state_t;

  cw_state_t  state_q;
  cmd_t       work_q;
  rgbw_t      hue_q;
  rgbw_t      tint_q;
  rgbw_t      duty_q;
  logic [7:0] hueCnt_q;
  logic [2:0] sector_q;
  logic       mulDone_q;
  rgbw_t      mulRes_q;

  assign cmdTaken = sysEn && (state_q == ST_IDLE) && cmdNew_q;
  assign busy     = (state_q != ST_IDLE);

  // Saturating step helpers for the hue sweep
  function automatic logic [7:0] satUp(input logic [7:0] v, input logic [7:0] s);
    logic [8:0] sum;
    sum = {1'b0, v} + {1'b0, s};
    satUp = sum[8] ? COMP_MAX : sum[7:0];
  endfunction

  function automatic logic [7:0] satDown(input logic [7:0] v, input logic [7:0] s);
    satDown = (v < s) ? COMP_MIN : v - s;
  endfunction

  // Sequencing between stages
  always_ff @(posedge sys_clk) begin
    if (sysRst) begin
      state_q <= ST_IDLE;
      work_q  <= '0;
    end else if (sysEn) begin
      case (state_q)
        ST_IDLE: begin
          if (cmdNew_q) begin
            work_q  <= activeCmd;
            state_q <= activeCmd.bypass ? ST_IDLE : ST_HUE;
          end
        end
        ST_HUE: begin
          if (hueCnt_q == work_q.colorIndex) begin
            state_q <= ST_TINT;
          end
        end
        ST_TINT: state_q <= ST_MUL;
        ST_MUL: begin
          if (mulDone_q) begin
            state_q <= ST_OUT;
          end
        end
        ST_OUT:  state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Hue sweep from red, no lookup table; latency grows with the index
  always_ff @(posedge sys_clk) begin
    if (sysRst) begin
      hue_q    <= '0;
      hueCnt_q <= 8'h00;
      sector_q <= 3'h0;
    end else if (sysEn) begin
      if (cmdTaken && !activeCmd.bypass) begin
        hue_q    <= '{r: COMP_MAX, g: COMP_MIN, b: COMP_MIN, w: COMP_MIN};
        hueCnt_q <= 8'h00;
        sector_q <= 3'h0;
      end else if (state_q == ST_HUE && hueCnt_q != work_q.colorIndex) begin
        hueCnt_q <= hueCnt_q + 8'h01;
        case (sector_q)
          3'h0: begin
            hue_q.g <= satUp(hue_q.g, HUE_STEP);
            if (satUp(hue_q.g, HUE_STEP) == COMP_MAX) sector_q <= 3'h1;
          end
          3'h1: begin
            hue_q.r <= satDown(hue_q.r, HUE_STEP);
            if (satDown(hue_q.r, HUE_STEP) == COMP_MIN) sector_q <= 3'h2;
          end
          3'h2: begin
            hue_q.b <= satUp(hue_q.b, HUE_STEP);
            if (satUp(hue_q.b, HUE_STEP) == COMP_MAX) sector_q <= 3'h3;
          end
          3'h3: begin
            hue_q.g <= satDown(hue_q.g, HUE_STEP);
            if (satDown(hue_q.g, HUE_STEP) == COMP_MIN) sector_q <= 3'h4;
          end
          3'h4: begin
            hue_q.r <= satUp(hue_q.r, HUE_STEP);
            if (satUp(hue_q.r, HUE_STEP) == COMP_MAX) sector_q <= 3'h5;
          end
          default: begin
            hue_q.b <= satDown(hue_q.b, HUE_STEP);
            if (satDown(hue_q.b, HUE_STEP) == COMP_MIN) sector_q <= 3'h0;
          end
        endcase
      end
    end
  end

  // Tint: white added to each hue component, clipped at full scale
  always_ff @(posedge sys_clk) begin
    if (sysRst) begin
      tint_q <= '0;
    end else if (sysEn && state_q == ST_TINT) begin
      tint_q.r <= satUp(hue_q.r, work_q.white);
      tint_q.g <= satUp(hue_q.g, work_q.white);
      tint_q.b <= satUp(hue_q.b, work_q.white);
      tint_q.w <= work_q.white;
    end
  end

  // ==========================================================
  // Shared intensity multiplier, full clock rate
  logic [2:0]  mulSlot_q;
  logic        mulRun_q;
  logic [7:0]  opA_q;
  logic [15:0] product;
  logic [7:0]  opSel;

  // Operand for the channel of the current slot pair
  always_comb begin
    case (mulSlot_q[2:1])
      2'h0:    opSel = tint_q.r;
      2'h1:    opSel = tint_q.g;
      2'h2:    opSel = tint_q.b;
      default: opSel = tint_q.w;
    endcase
  end

  assign product = opA_q * work_q.intensity;

  // Even slot loads an operand, odd slot takes the product: two fast
  // cycles per channel, so each fits one system cycle
  always_ff @(posedge sys_clk) begin
    if (sysRst) begin
      mulSlot_q <= 3'h0;
      mulRun_q  <= 1'b0;
      mulDone_q <= 1'b0;
      opA_q     <= 8'h00;
      mulRes_q  <= '0;
    end else if (ce) begin
      if (state_q != ST_MUL) begin
        mulDone_q <= 1'b0;
        mulRun_q  <= 1'b0;
        mulSlot_q <= 3'h0;
      end else if (!mulRun_q && !mulDone_q) begin
        mulRun_q <= 1'b1;
      end else if (mulRun_q) begin
        if (!mulSlot_q[0]) begin
          opA_q <= opSel;
        end else begin
          case (mulSlot_q[2:1])
            2'h0:    mulRes_q.r <= product[15:8];
            2'h1:    mulRes_q.g <= product[15:8];
            2'h2:    mulRes_q.b <= product[15:8];
            default: mulRes_q.w <= product[15:8];
          endcase
        end
        mulSlot_q <= mulSlot_q + 3'h1;
        if (mulSlot_q == MUL_LAST_SLOT) begin
          mulRun_q  <= 1'b0;
          mulDone_q <= 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // Duty registers feeding the modulator
  always_ff @(posedge sys_clk) begin
    if (sysRst) begin
      duty_q <= '{r: DUTY_RESET, g: DUTY_RESET, b: DUTY_RESET, w: DUTY_RESET};
    end else if (sysEn) begin
      if (cmdTaken && activeCmd.bypass) begin
        duty_q.r <= activeCmd.red;
        duty_q.g <= activeCmd.green;
        duty_q.b <= activeCmd.blue;
        duty_q.w <= activeCmd.white;
      end else if (state_q == ST_OUT) begin
        duty_q <= mulRes_q;
      end
    end
  end

  // ==========================================================
  // Four channel modulator on the prescaled tick
  logic [PWM_BITS-1:0] pwmCnt_q;
  logic [7:0]          chanDuty [4];

  always_ff @(posedge sys_clk) begin
    if (sysRst) begin
      pwmCnt_q <= '0;
    end else if (sysEn) begin
      pwmCnt_q <= pwmCnt_q + 1'b1;
    end
  end

  assign chanDuty[0] = duty_q.r;
  assign chanDuty[1] = duty_q.g;
  assign chanDuty[2] = duty_q.b;
  assign chanDuty[3] = duty_q.w;

  for (genvar ch = 0; ch < 4; ch++) begin : g_pwm
    pwm_channel #(
      .WIDTH (PWM_BITS)
    ) u_pwm (
      .sys_clk (sys_clk),
      .rst     (sysRst),
      .en      (sysEn),
      .cnt     (pwmCnt_q),
      .duty    (PWM_BITS'(chanDuty[ch])),
      .pwm     (dedicatedOutputs[ch])
    );
  end

  // ==========================================================
  // Debug view of the colour wheel unit
  // Pins stay released unless debug is asked for, so a board can
  // still use them as inputs
  always_ff @(posedge sys_clk) begin
    if (sysRst) begin
      debugOut <= 8'h00;
      debugOe  <= 8'h00;
    end else if (ce) begin
      debugOe  <= {8{debugEn}};
      debugOut <= debugEn ? {state_q, sector_q} : 8'h00;
    end
  end

endmodule
`default_nettype wire

// ### rgbw_color_pwm_checker.sv
`timescale 1ns/1ps
`default_nettype none
module rgbw_color_pwm_checker #(
  parameter int PWM_BITS = 8
) (
  // Clock, reset, enable
  input wire logic           sys_clk,
  input wire logic           nrst,
  input wire logic           ce,
  // Serial pins
  input wire logic           csN,
  input wire logic           sck,
  input wire logic           mosi,
  // Debug pins
  input wire logic           debugEn,
  input wire logic [7:0]     debugOut,
  input wire logic [7:0]     debugOe,
  // Outputs and status
  input wire logic [3:0]     dedicatedOutputs,
  input wire logic           busy,
  input wire rgbw_pkg::cmd_t activeCmd
);
  import rgbw_pkg::*;
  logic [7:0] holdQ;
  logic [8:0] gapQ;
  logic       seenQ;
  logic       ready;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);

  // ====================
  // Helper counters
  // Cycles since release; saturates well past the hold
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      holdQ <= 8'h00;
    end else if (ce && holdQ != 8'hC8) begin
      holdQ <= holdQ + 8'h01;
    end
  end
  assign ready = (holdQ == 8'hC8);

  // Cycles since last red rise, 9 bits so whole periods wrap
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      gapQ  <= 9'h000;
      seenQ <= 1'b0;
    end else if ($rose(dedicatedOutputs[0])) begin
      gapQ  <= 9'h000;
      seenQ <= ready && ce;
    end else begin
      gapQ  <= gapQ + 9'h001;
      if (!ce) begin
        seenQ <= 1'b0; // Frozen cycles stretch the period, so skip it
      end
    end
  end

  // ====================
  // Sequences and properties
  sequence wheelLoad;
    ready && !$stable(activeCmd) && !activeCmd.bypass;
  endsequence
  sequence wheelEnd;
    ##[1:1000] !busy;
  endsequence

  chk_hold_quiet: assert property (holdQ < 8'h7F |->
    dedicatedOutputs == 4'h0 && activeCmd == '0 && debugOe == 8'h00 && !busy)
    else $error("outputs active during reset hold");
  chk_dbg_drive: assert property (ready && debugEn |=> debugOe == 8'hFF)
    else $error("debug pins not driven");
  chk_dbg_off: assert property (!debugEn |=> debugOe == 8'h00 && debugOut == 8'h00)
    else $error("debug pins active while disabled");
  chk_cmd_after_cs: assert property (!$stable(activeCmd) |-> csN)
    else $error("command changed inside a byte");
  chk_wheel_starts: assert property (wheelLoad |-> ##[0:8] busy)
    else $error("wheel command did not start");
  chk_wheel_ends: assert property ($rose(busy) |-> wheelEnd)
    else $error("wheel processing did not finish");
  chk_busy_is_wheel: assert property ($rose(busy) |-> !activeCmd.bypass)
    else $error("processing started in bypass");
  chk_pwm_period: assert property (seenQ && $rose(dedicatedOutputs[0]) |-> gapQ == 9'h1FF)
    else $error("pwm edge off period start");
endmodule

bind rgbw_color_pwm rgbw_color_pwm_checker #(.PWM_BITS(PWM_BITS)) u_chk (
  .sys_clk(sys_clk), .nrst(nrst), .ce(ce), .csN(csN), .sck(sck), .mosi(mosi),
  .debugEn(debugEn), .debugOut(debugOut), .debugOe(debugOe),
  .dedicatedOutputs(dedicatedOutputs), .busy(busy), .activeCmd(activeCmd)
);
`default_nettype wire

// ### spi_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  // Clock
  input  wire logic sys_clk,
  // Serial pins toward the device
  output var logic  csN,
  output var logic  sck,
  output var logic  mosi
);
  // ====================
  // Idle levels: clock parked low between frames
  initial begin
    csN  = 1'b1;
    sck  = 1'b0;
    mosi = 1'b1;
  end

  // Let n edges pass, then move just after the edge
  task automatic gap(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // One byte per select; data moves only while clock is low
  task automatic sendByte(input logic [7:0] b);
    csN = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      mosi = b[i];
      gap(4);
      sck = 1'b1;
      gap(4);
      sck = 1'b0;
    end
    gap(4);
    csN  = 1'b1;
    mosi = ~mosi; // Released line has no pull, so no stale data
    gap(12);
  endtask

  // Whole command, first byte in the top bits
  task automatic sendCmd(input logic [63:0] c);
    for (int k = 7; k >= 0; k--) begin
      sendByte(c[k*8 +: 8]);
    end
  endtask
endmodule
`default_nettype wire

// ### spi_rgbw_color_pwm_test.sv
`timescale 1ns/1ps
`default_nettype none
module spi_rgbw_color_pwm_test;
  import rgbw_pkg::*;
  logic       sys_clk;
  logic       nrst;
  logic       ce;
  logic       debugEn;
  logic       csN;
  logic       sck;
  logic       mosi;
  logic [7:0] debugOut;
  logic [7:0] debugOe;
  logic [3:0] dedicatedOutputs;
  logic       busy;
  cmd_t       activeCmd;
  cmd_t       lastCmd;
  logic [3:0] frozenPwm;
  int         movedCnt;
  int         fails;
  int         samples_checked;

  // ====================
  // Clock and instances
  initial sys_clk = 1'b0;
  always #2.5 sys_clk = ~sys_clk;

  rgbw_color_pwm u_dut (
    .sys_clk(sys_clk), .nrst(nrst), .ce(ce), .csN(csN), .sck(sck), .mosi(mosi),
    .debugEn(debugEn), .debugOut(debugOut), .debugOe(debugOe),
    .dedicatedOutputs(dedicatedOutputs), .busy(busy), .activeCmd(activeCmd)
  );
  spi_host_model u_host (.sys_clk(sys_clk), .csN(csN), .sck(sck), .mosi(mosi));

  // ====================
  // Shared tasks
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic tally_and_finish;
    if (fails == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // High time over one full period, sampled away from the edge
  task automatic duties(input logic [31:0] exp);
    logic [9:0] hi [4];
    step(1100);
    for (int c = 0; c < 4; c++) hi[c] = 10'h000;
    repeat (512) begin
      @(negedge sys_clk);
      for (int c = 0; c < 4; c++) hi[c] += dedicatedOutputs[c];
    end
    for (int c = 0; c < 4; c++) begin
      check($sformatf("pwm%0d", c), hi[c], {exp[31-8*c -: 8], 1'b0});
    end
    step(1);
  endtask

  // Bounded wait for wheel processing to finish
  task automatic waitIdle;
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 2000) begin
      step(1);
      n++;
    end
    check("busy_done", busy, 1'b0);
  endtask

  // ====================
  // Watchdog, well past the expected run length
  initial begin
    repeat (60000) @(posedge sys_clk);
    fails++;
    tally_and_finish;
  end

  // ====================
  // Test sequence
  initial begin
    fails = 0;
    samples_checked = 0;
    nrst = 1'b0;
    ce = 1'b1;
    debugEn = 1'b0;
    step(10);
    nrst = 1'b1;
    step(140);
    check("cmd_reset", activeCmd, 57'h0);
    check("pwm_reset", dedicatedOutputs, 4'h0);
    debugEn = 1'b1;
    step(2);
    check("oe_on", debugOe, 8'hFF);
    check("dbg_idle", debugOut, 8'h08);
    debugEn = 1'b0;
    step(2);
    check("oe_off", debugOe, 8'h00);
    // Bypass: raw bytes, intensity must not scale them
    u_host.sendCmd(64'h5511_22C3_3CFF_0021);
    step(8);
    check("cmd_bypass", activeCmd, {56'h1122_C33C_FF00, 1'b1});
    duties(32'hC33C_FF00);
    // Clock enable low: every PWM output must hold still
    ce = 1'b0;
    frozenPwm = dedicatedOutputs;
    movedCnt = 0;
    repeat (600) begin
      @(negedge sys_clk);
      if (dedicatedOutputs !== frozenPwm) movedCnt++;
    end
    check("ce_freeze", movedCnt, 0);
    step(1);
    ce = 1'b1;
    // Unknown mode byte drops the whole packet
    lastCmd = {56'h1122_C33C_FF00, 1'b1};
    u_host.sendCmd(64'h5500_0011_2233_445A);
    step(8);
    check("cmd_badmode", activeCmd, lastCmd);
    // Broken packet then garbage resynchronises
    u_host.sendByte(8'h55);
    u_host.sendByte(8'h01);
    u_host.sendByte(8'h02);
    repeat (9) u_host.sendByte(8'hAA);
    check("cmd_partial", activeCmd, lastCmd);
    // Wheel at index zero; red byte is ignored
    u_host.sendCmd(64'h5580_0011_2233_40A4);
    step(8);
    check("cmd_wheel", activeCmd, {56'h8000_1122_3340, 1'b0});
    waitIdle;
    duties(32'h7F20_2020);
    // Tint saturates, product keeps its upper byte
    u_host.sendCmd(64'h55FF_0000_0000_FFA4);
    step(8);
    waitIdle;
    duties(32'hFEFE_FEFE);
    // Large index means long processing
    u_host.sendCmd(64'h5510_FF00_0000_00A4);
    step(200);
    check("busy_long", busy, 1'b1);
    waitIdle;
    duties(32'h0F00_0000);
    // Second reset in mid-run, then a fresh packet
    nrst = 1'b0;
    step(10);
    nrst = 1'b1;
    step(2);
    check("cmd_rst2", activeCmd, 57'h0);
    step(140);
    u_host.sendCmd(64'h5500_0001_0203_0421);
    step(8);
    check("cmd_after_rst", activeCmd, {56'h0000_0102_0304, 1'b1});
    tally_and_finish;
  end
endmodule
`default_nettype wire
